// *** rtl/rest_ctrl_if.sv ***
// Register-access link between the microcontroller and the sensor
`timescale 1ns/1ps
interface rest_ctrl_if;
	logic wr_stb;
	logic rd_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	modport sensor (input wr_stb, input rd_stb, input addr, input wdata, output rdata, output rvalid);
	modport mcu (output wr_stb, output rd_stb, output addr, output wdata, input rdata, input rvalid);
endinterface : rest_ctrl_if

// *** rtl/rest_ctrl_map.svh ***
// Register offsets, field positions, reset values and timing counts of the power-mode control block
`ifndef REST_CTRL_MAP_SVH
`define REST_CTRL_MAP_SVH
`define ADDR_MODE_CONTROL 7'h10
`define ADDR_FRAME_GRAB 7'h12
`define ADDR_FW_LOAD 7'h13
`define ADDR_RUN_IDLE 7'h14
`define ADDR_SLEEP_LEVEL_ONE_PERIOD 7'h15
`define ADDR_SLEEP_LEVEL_ONE_IDLE 7'h16
`define ADDR_MODE_STATUS 7'h3F
`define FLD_FORCE_HI 7
`define FLD_FORCE_LO 6
`define FLD_REST_EN 5
`define FLD_EXPO_OFF 4
`define FLD_FIXED_FRAME_PERIOD 3
`define FLD_RPT_MOD 2
`define RST_MODE_CONTROL 8'h00
`define RST_RUN_IDLE 8'h32
`define RST_SLEEP_LEVEL_ONE_PERIOD 8'h01
`define RST_SLEEP_LEVEL_ONE_IDLE 8'h1F
`define FW_CRC_CODE 8'h15
`define CLK_HZ 50000000
`define TICK_MS 10
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_MS)
`define CRC_WAIT_MS 10
`define SLEEP_LEVEL_ONE_IDLE_MULT 16
`endif

// *** rtl/rest_ctrl_pkg.sv ***
// Types of the power-mode control link, used by the sensor end only
package rest_ctrl_pkg;
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP1,
		MODE_SLEEP2,
		MODE_SLEEP3
	} power_mode_e;
	typedef enum logic [1:0] {
		FW_IDLE,
		FW_DOWNLOAD,
		FW_CRC_TEST,
		FW_CAPTURE
	} fw_state_e;
endpackage : rest_ctrl_pkg

// *** rtl/rest_mcu.sv ***
// Controller end: issues register accesses, sequences the CRC test and flags reload after capture
`timescale 1ns/1ps
`include "rest_ctrl_map.svh"
module rest_mcu #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	rest_ctrl_if.mcu bus,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [6:0] req_addr_i,
	input wire logic [7:0] req_wdata_i,
	input wire logic laser_fault_i,
	output logic busy_o,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	output logic reload_needed_o
);
	logic wr_q, rd_q, busy_q, reload_q;
	logic [6:0] addr_q;
	logic [7:0] wdata_q;
	logic [31:0] wait_q;
	logic tick;
	tick_divider #(.PERIOD(TICK_CYCLES)) u_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);
	wire is_crc = req_write_i && req_addr_i == `ADDR_FW_LOAD && req_wdata_i == `FW_CRC_CODE;
	// CRC start refused on laser fault; port blocked while test runs
	wire accept = req_i && !busy_q && !(is_crc && laser_fault_i);
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= 7'h00;
			wdata_q <= 8'h00;
			busy_q <= 1'b0;
			wait_q <= 32'h0;
			reload_q <= 1'b0;
		end else begin
			wr_q <= accept && req_write_i;
			rd_q <= accept && !req_write_i;
			if (accept) begin
				addr_q <= req_addr_i;
				wdata_q <= req_wdata_i;
			end
			if (accept && is_crc) begin
				busy_q <= 1'b1;
				wait_q <= 32'(`CRC_WAIT_MS / `TICK_MS + 1);
			end else if (busy_q && tick) begin
				wait_q <= wait_q - 32'h1;
				busy_q <= wait_q != 32'h1;
			end
			if (accept && req_write_i && req_addr_i == `ADDR_FRAME_GRAB)
				reload_q <= 1'b1;
		end
	end
	assign bus.wr_stb = wr_q;
	assign bus.rd_stb = rd_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_o <= 1'b0;
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
			reload_needed_o <= 1'b0;
		end else begin
			busy_o <= busy_q;
			rdata_o <= bus.rvalid ? bus.rdata : rdata_o;
			rvalid_o <= bus.rvalid;
			reload_needed_o <= reload_q;
		end
	end
endmodule : rest_mcu

// *** rtl/rest_sensor.sv ***
// Sensor end: power-mode state machine, configuration registers and firmware triggers
//
// Functional notes
// - Force code 01/10/11 selects sleep level one/two/three
// - Release from level one steps down or wakes
// - Release from level two steps down or wakes
// - Release from level three stays or wakes
// - Rest enable bit gates all sleep levels
// - Exposure-off bit freezes exposure at max bound
// - Fixed-rate bit takes period from max bound
// - Report mode splits X and Y resolution
// - Frame-grab write overwrites firmware, halts navigation
// - Controller resets and reloads after frame grab; rest_mcu only raises reload_needed_o
// - Firmware trigger starts download or CRC test
// - Navigation halts during CRC; controller stays off port
// - Controller writes CRC code, waits 10ms, reads
// - Controller should check laser fault first
// - Run idle timeout is value times 10ms
// - Level one frames every value plus one ticks
// - Held force code pins the sleep level
// - Level one idle timeout is value*16 frames
`timescale 1ns/1ps
`include "rest_ctrl_map.svh"
module rest_sensor #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	rest_ctrl_if.sensor bus,
	input wire logic motion_i,
	output rest_ctrl_pkg::power_mode_e mode_o,
	output logic frame_o,
	output logic nav_halt_o,
	output logic exposure_auto_off_o,
	output logic fixed_frame_period_o,
	output logic split_resolution_o,
	output logic fw_download_start_o,
	output logic fw_crc_start_o,
	output logic frame_grab_start_o
);
	rest_ctrl_pkg::power_mode_e mode_q, mode_d;
	logic [7:0] mode_control_q, run_idle_timeout_q, sleep_level_one_period_q, sleep_level_one_idle_timeout_q;
	logic [7:0] run_count_q, sleep_level_one_period_count_q;
	logic [11:0] sleep_level_one_idle_count_q;
	logic motion_s1_q, motion_s2_q;
	logic nav_halt_q, capture_halt_q;
	logic [7:0] crc_wait_q;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic tick;

	tick_divider #(.PERIOD(TICK_CYCLES)) u_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	wire wr_mode = bus.wr_stb && (bus.addr == `ADDR_MODE_CONTROL);
	wire wr_grab = bus.wr_stb && (bus.addr == `ADDR_FRAME_GRAB);
	wire wr_fw = bus.wr_stb && (bus.addr == `ADDR_FW_LOAD);
	wire crc_req = wr_fw && (bus.wdata == `FW_CRC_CODE);
	wire [1:0] force_code = mode_control_q[`FLD_FORCE_HI:`FLD_FORCE_LO];
	wire rest_en = mode_control_q[`FLD_REST_EN];
	wire motion = motion_s2_q;
	// Look at the next count so the last tick of the wait is the one that downshifts
	wire run_expired = (run_count_q + 8'h01 >= run_idle_timeout_q) && (run_idle_timeout_q != 8'h00);
	wire frame_due = tick && (sleep_level_one_period_count_q >= sleep_level_one_period_q);
	wire [11:0] sleep_level_one_limit = {sleep_level_one_idle_timeout_q, 4'h0};
	// Frame that completes value*16 frames is the one that steps down
	wire sleep_level_one_expired = (sleep_level_one_idle_count_q + 12'h001 >= sleep_level_one_limit);

	always_comb begin
		mode_d = mode_q;
		if (!rest_en) begin
			mode_d = rest_ctrl_pkg::MODE_RUN;
		end else begin
			case (force_code)
				2'b01: mode_d = rest_ctrl_pkg::MODE_SLEEP1;
				2'b10: mode_d = rest_ctrl_pkg::MODE_SLEEP2;
				2'b11: mode_d = rest_ctrl_pkg::MODE_SLEEP3;
				default: begin
					case (mode_q)
						rest_ctrl_pkg::MODE_RUN: if (tick && run_expired && !motion) mode_d = rest_ctrl_pkg::MODE_SLEEP1;
						rest_ctrl_pkg::MODE_SLEEP1: begin
							if (motion) mode_d = rest_ctrl_pkg::MODE_RUN;
							else if (frame_due && sleep_level_one_expired) mode_d = rest_ctrl_pkg::MODE_SLEEP2;
						end
						rest_ctrl_pkg::MODE_SLEEP2: begin
							// No level two idle timer in this design; step down on the next tick
							if (motion) mode_d = rest_ctrl_pkg::MODE_RUN;
							else if (tick) mode_d = rest_ctrl_pkg::MODE_SLEEP3;
						end
						rest_ctrl_pkg::MODE_SLEEP3: if (motion) mode_d = rest_ctrl_pkg::MODE_RUN;
						default: mode_d = rest_ctrl_pkg::MODE_RUN;
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			motion_s1_q <= 1'b0;
			motion_s2_q <= 1'b0;
			mode_q <= rest_ctrl_pkg::MODE_RUN;
		end else begin
			motion_s1_q <= motion_i;
			motion_s2_q <= motion_s1_q;
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mode_control_q <= `RST_MODE_CONTROL;
			run_idle_timeout_q <= `RST_RUN_IDLE;
			sleep_level_one_period_q <= `RST_SLEEP_LEVEL_ONE_PERIOD;
			sleep_level_one_idle_timeout_q <= `RST_SLEEP_LEVEL_ONE_IDLE;
		end else if (bus.wr_stb) begin
			case (bus.addr)
				`ADDR_MODE_CONTROL: mode_control_q <= {bus.wdata[7:2], 2'b00};
				`ADDR_RUN_IDLE: run_idle_timeout_q <= bus.wdata;
				`ADDR_SLEEP_LEVEL_ONE_PERIOD: sleep_level_one_period_q <= bus.wdata;
				`ADDR_SLEEP_LEVEL_ONE_IDLE: sleep_level_one_idle_timeout_q <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Idle timers restart on motion or any mode change
	wire restart = motion || (mode_d != mode_q) || wr_mode;
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			run_count_q <= 8'h00;
			sleep_level_one_period_count_q <= 8'h00;
			sleep_level_one_idle_count_q <= 12'h000;
		end else if (restart) begin
			run_count_q <= 8'h00;
			sleep_level_one_period_count_q <= 8'h00;
			sleep_level_one_idle_count_q <= 12'h000;
		end else if (tick) begin
			if (mode_q == rest_ctrl_pkg::MODE_RUN && !run_expired)
				run_count_q <= run_count_q + 8'h01;
			if (mode_q == rest_ctrl_pkg::MODE_SLEEP1) begin
				sleep_level_one_period_count_q <= frame_due ? 8'h00 : sleep_level_one_period_count_q + 8'h01;
				if (frame_due && !sleep_level_one_expired)
					sleep_level_one_idle_count_q <= sleep_level_one_idle_count_q + 12'h001;
			end
		end
	end

	// Halt stays until reset: a frame grab destroys the firmware image
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			capture_halt_q <= 1'b0;
			crc_wait_q <= 8'h00;
			nav_halt_q <= 1'b0;
		end else begin
			if (wr_grab)
				capture_halt_q <= 1'b1;
			if (crc_req)
				crc_wait_q <= 8'(`CRC_WAIT_MS / `TICK_MS);
			else if (tick && crc_wait_q != 8'h00)
				crc_wait_q <= crc_wait_q - 8'h01;
			nav_halt_q <= capture_halt_q || wr_grab || crc_req || (crc_wait_q != 8'h00);
		end
	end

	wire [7:0] status = {6'h00, mode_q};
	wire [7:0] rd_mux = (bus.addr == `ADDR_MODE_CONTROL) ? mode_control_q :
		(bus.addr == `ADDR_RUN_IDLE) ? run_idle_timeout_q :
		(bus.addr == `ADDR_SLEEP_LEVEL_ONE_PERIOD) ? sleep_level_one_period_q :
		(bus.addr == `ADDR_SLEEP_LEVEL_ONE_IDLE) ? sleep_level_one_idle_timeout_q :
		(bus.addr == `ADDR_MODE_STATUS) ? status : 8'h00;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
			mode_o <= rest_ctrl_pkg::MODE_RUN;
			frame_o <= 1'b0;
			nav_halt_o <= 1'b0;
			exposure_auto_off_o <= 1'b0;
			fixed_frame_period_o <= 1'b0;
			split_resolution_o <= 1'b0;
			fw_download_start_o <= 1'b0;
			fw_crc_start_o <= 1'b0;
			frame_grab_start_o <= 1'b0;
		end else begin
			rdata_q <= bus.rd_stb ? rd_mux : rdata_q;
			rvalid_q <= bus.rd_stb;
			mode_o <= mode_q;
			frame_o <= (mode_q == rest_ctrl_pkg::MODE_SLEEP1) && frame_due && !restart;
			nav_halt_o <= nav_halt_q;
			exposure_auto_off_o <= mode_control_q[`FLD_EXPO_OFF];
			fixed_frame_period_o <= mode_control_q[`FLD_FIXED_FRAME_PERIOD];
			split_resolution_o <= mode_control_q[`FLD_RPT_MOD];
			fw_download_start_o <= wr_fw && !crc_req;
			fw_crc_start_o <= crc_req;
			frame_grab_start_o <= wr_grab;
		end
	end

	assign bus.rdata = rdata_q;
	assign bus.rvalid = rvalid_q;
endmodule : rest_sensor

// *** rtl/tick_divider.sv ***
// Divider producing a one-cycle enable pulse every PERIOD clocks
`timescale 1ns/1ps
module tick_divider #(
	parameter int PERIOD = 500000
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	output logic tick_o
);
	logic [31:0] cnt_q;
	wire wrap = (cnt_q == 32'(PERIOD - 1));
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
			tick_o <= wrap;
		end
	end
endmodule : tick_divider

// *** test/rest_ctrl_properties.sv ***
// Timing checks on the register link between controller and sensor
`timescale 1ns/1ps
`include "rest_ctrl_map.svh"
module rest_ctrl_properties #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	localparam int CRC_GAP = (`CRC_WAIT_MS / `TICK_MS) * TICK_CYCLES;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire crc_go = wr_stb && addr == `ADDR_FW_LOAD && wdata == `FW_CRC_CODE;
	wire any_stb = wr_stb || rd_stb;
	int quiet_q;
	// Saturates so a long quiet run never wraps
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) quiet_q <= CRC_GAP;
		else if (crc_go) quiet_q <= 0;
		else if (quiet_q < CRC_GAP) quiet_q <= quiet_q + 1;
	end
	rd_answer_a: assert property (rd_stb |=> rvalid)
		else $error("read strobe not answered");
	rvalid_cause_a: assert property (rvalid |-> $past(rd_stb))
		else $error("answer without read strobe");
	rdata_hold_a: assert property (!rd_stb |=> $stable(rdata))
		else $error("read data moved without read");
	crc_quiet_a: assert property (crc_go |=> !any_stb [*8])
		else $error("port used during test");
	crc_wait_a: assert property (any_stb |-> quiet_q >= CRC_GAP - 1)
		else $error("access before test wait ended");
	unmapped_read_a: assert property (rd_stb && addr == 7'h7E |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_low_bits_a: assert property (rd_stb && addr == `ADDR_MODE_CONTROL |=> rdata[1:0] == 2'h0)
		else $error("mode control low bits set");
	period_back_a: assert property (wr_stb && addr == `ADDR_SLEEP_LEVEL_ONE_PERIOD ##1 rd_stb && addr == `ADDR_SLEEP_LEVEL_ONE_PERIOD
		|=> rdata == $past(wdata, 2))
		else $error("period readback wrong");
endmodule : rest_ctrl_properties

// *** test/tb.sv ***
// Bench joining controller and sensor ends across the register link
`timescale 1ns/1ps
`include "rest_ctrl_map.svh"
module tb;
	localparam int TK = 10;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic motion_i = 1'b0;
	logic req_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [6:0] req_addr_i = 7'h00;
	logic [7:0] req_wdata_i = 8'h00;
	logic laser_fault_i = 1'b0;
	rest_ctrl_pkg::power_mode_e mode_o;
	logic frm, halt, expo, fixd, splt, dl, crc, grab, busy, rvalid_o, reload;
	logic [7:0] rdata_o;
	logic [7:0] q[$];
	logic [7:0] v;
	logic [7:0] e;
	int fails = 0;
	int compares = 0;
	int seed = 78238;
	int n;
	wire [3:0] md = 4'h1 << mode_o;
	wire [9:0] ev = {halt, !busy, frm, dl, crc, grab, md};
	always #10 ref_clk_i = ~ref_clk_i;
	rest_ctrl_if rest_ctrl_if_i();
	rest_sensor #(.TICK_CYCLES(TK)) rest_sensor_i(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.bus(rest_ctrl_if_i.sensor), .motion_i(motion_i), .mode_o(mode_o), .frame_o(frm), .nav_halt_o(halt),
		.exposure_auto_off_o(expo), .fixed_frame_period_o(fixd), .split_resolution_o(splt),
		.fw_download_start_o(dl), .fw_crc_start_o(crc), .frame_grab_start_o(grab));
	rest_mcu #(.TICK_CYCLES(TK)) rest_mcu_i(.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.bus(rest_ctrl_if_i.mcu), .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
		.req_wdata_i(req_wdata_i), .laser_fault_i(laser_fault_i), .busy_o(busy), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .reload_needed_o(reload));
	rest_ctrl_properties #(.TICK_CYCLES(TK)) rest_ctrl_properties_i(.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .wr_stb(rest_ctrl_if_i.wr_stb), .rd_stb(rest_ctrl_if_i.rd_stb),
		.addr(rest_ctrl_if_i.addr), .wdata(rest_ctrl_if_i.wdata), .rdata(rest_ctrl_if_i.rdata),
		.rvalid(rest_ctrl_if_i.rvalid));
	task chk(input string nm, input logic [7:0] s, input logic [7:0] x);
		compares++;
		if (s !== x) begin
			fails++;
			$display("ERROR %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task end_sim;
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	// Leaves the request up so calls run back to back
	task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		req_i <= 1'b1;
		req_write_i <= w;
		req_addr_i <= a;
		req_wdata_i <= d;
		if (!w) q.push_back(d);
	endtask : acc
	task gap(input int c);
		@(posedge ref_clk_i);
		req_i <= 1'b0;
		repeat (c) @(posedge ref_clk_i);
	endtask : gap
	task wt(input int b, input int lim);
		n = 0;
		while (ev[b] !== 1'b1 && n < lim) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		chk("event", {7'h00, ev[b]}, 8'h01);
		if (n >= lim) end_sim();
	endtask : wt
	always @(posedge ref_clk_i) begin
		if (rvalid_o === 1'b1) begin
			e = q.size() > 0 ? q.pop_front() : ~rdata_o;
			chk("rdata", rdata_o, e);
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		v = $random(seed);
		acc(0, `ADDR_SLEEP_LEVEL_ONE_PERIOD, 8'h01);
		acc(0, `ADDR_RUN_IDLE, 8'h32);
		acc(0, `ADDR_MODE_CONTROL, 8'h00);
		acc(0, 7'h7E, 8'h00);
		acc(1, `ADDR_SLEEP_LEVEL_ONE_PERIOD, v);
		acc(0, `ADDR_SLEEP_LEVEL_ONE_PERIOD, v);
		acc(1, `ADDR_SLEEP_LEVEL_ONE_PERIOD, 8'h01);
		acc(1, `ADDR_SLEEP_LEVEL_ONE_IDLE, 8'h01);
		gap(4);
		for (int i = 0; i < 3; i++) begin
			acc(1, `ADDR_MODE_CONTROL, 8'h04 << i);
			gap(4);
			chk("cfg", {5'h00, expo, fixd, splt}, 8'h01 << i);
		end
		for (int i = 1; i < 4; i++) begin
			motion_i <= 1'b1;
			wt(0, 60);
			acc(1, `ADDR_MODE_CONTROL, {i[1:0], 6'h20});
			gap(1);
			wt(i, 20);
			repeat (40) @(posedge ref_clk_i);
			chk("held", {7'h00, ev[i]}, 8'h01);
			motion_i <= 1'b0;
			acc(1, `ADDR_MODE_CONTROL, 8'h20);
			gap(4);
			wt(i == 3 ? 3 : i + 1, 400);
			if (i == 1) chk("idle1", {7'h00, n > 15 * 2 * TK && n <= 16 * 2 * TK}, 8'h01);
			wt(3, 40);
			repeat (60) @(posedge ref_clk_i);
			chk("stay3", {7'h00, ev[3]}, 8'h01);
		end
		acc(1, `ADDR_MODE_CONTROL, 8'h40);
		gap(40);
		chk("noRest", {7'h00, ev[0]}, 8'h01);
		motion_i <= 1'b1;
		acc(1, `ADDR_RUN_IDLE, 8'h03);
		acc(1, `ADDR_MODE_CONTROL, 8'h20);
		gap(4);
		motion_i <= 1'b0;
		wt(1, 80);
		chk("runIdle", {7'h00, n >= 2 * TK && n <= 3 * TK + 5}, 8'h01);
		acc(1, `ADDR_SLEEP_LEVEL_ONE_PERIOD, 8'h02);
		acc(1, `ADDR_MODE_CONTROL, 8'h60);
		gap(1);
		wt(7, 100);
		@(posedge ref_clk_i);
		#1;
		wt(7, 100);
		chk("frame", n[7:0] + 8'h01, 8'h1E);
		acc(1, `ADDR_FW_LOAD, v | 8'h80);
		gap(0);
		wt(6, 10);
		laser_fault_i <= 1'b1;
		acc(1, `ADDR_FW_LOAD, 8'h15);
		gap(10);
		chk("refuse", {7'h00, busy}, 8'h00);
		laser_fault_i <= 1'b0;
		acc(1, `ADDR_FW_LOAD, 8'h15);
		gap(0);
		wt(5, 10);
		// Halt output trails the start pulse by one register stage
		@(posedge ref_clk_i);
		#1;
		chk("crcHalt", {6'h00, halt, busy}, 8'h03);
		wt(8, 300);
		acc(1, `ADDR_FRAME_GRAB, v);
		gap(0);
		wt(4, 10);
		wt(9, 10);
		chk("reload", {7'h00, reload}, 8'h01);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk("clear", {6'h00, halt, reload}, 8'h00);
		chk("queue", 8'(q.size()), 8'h00);
		end_sim();
	end
endmodule : tb
